// ===== rtl/fdc_command_decoder.v
// Operation
// - Command and result bytes pass only while port_select_line is high.
// - Don't-care opcode and parameter bits are masked off when decoding.
// - All parameter bytes are collected before execution starts.
// - In no-DMA mode an interrupt is raised for every data byte.
// - In DMA mode execution bytes move by request/acknowledge only.
// - Read-ID stores the first good sector identifier into the data register.
// - Read-ID returns three status bytes then cylinder, head, sector, size.
// - Format writes a whole track of the selected drive and head, then results.
// - Scan-equal decodes from low bits 10001 with flags in the upper three bits.
// - Scan compares disk bytes to system bytes, returns status and identifier.
// - Scan-high-or-equal takes a sector step and returns status and identifier.
// - Recalibrate steps to cylinder zero, no result phase.
// - Sense-interrupt returns status zero and present cylinder of finished drive.
// - Timing setup takes three bytes and returns nothing.
// - Seek steps the selected head until it reaches the target cylinder.
// - Seeks on four drives run at the same time.
// - Undefined opcodes return one status byte of 80H.
// - Sector sizes 128 to 8192 bytes selected by size code.
// - Step interval is 1 to 16 ms in 1 ms units, shared by drives.
// - Load delay is 2 to 254 ms in 2 ms steps.
// - Unload delay is 16 to 240 ms in 16 ms steps.
// - No-DMA flag set selects interrupts, clear selects DMA.
`timescale 1ns/1ps
`include "fdc_consts.vh"
module fdc_command_decoder #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_wr_strobe,
  input wire i_rd_strobe,
  input wire i_port_select_line,
  input wire [7:0] i_host_data,
  input wire i_dma_ack,
  input wire i_terminal_count,
  input wire i_index,
  input wire i_track_zero,
  input wire i_id_valid,
  input wire [31:0] i_id_fields,
  input wire i_disk_byte_valid,
  input wire [7:0] i_disk_byte,
  input wire [3:0] i_drive_ready,
  output reg [7:0] o_host_data,
  output wire o_cmd_busy,
  output wire o_result_ready,
  output wire o_exec_phase,
  output wire o_int_req,
  output wire o_dma_req,
  output reg o_step,
  output reg o_step_dir,
  output reg [1:0] o_unit_select,
  output reg o_head_select_bit,
  output reg o_head_load,
  output reg o_write_byte_valid,
  output reg [7:0] o_write_byte,
  output reg o_scan_match
);
  localparam ST_IDLE = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_EXEC = 3'h2;
  localparam ST_SETTLE = 3'h3;
  localparam ST_RES = 3'h4;

  reg r1_q;
  reg rst_n;
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      r1_q <= 1'b1;
      rst_n <= r1_q;
    end
  end

  reg [2:0] state_q;
  reg [7:0] cmd_q [0:8];
  reg [7:0] res_q [0:6];
  reg [3:0] cmd_idx_q;
  reg [3:0] cmd_len_q;
  reg [2:0] res_idx_q;
  reg [2:0] res_len_q;
  reg [3:0] step_interval_field;
  reg [3:0] unload_delay_field;
  reg [6:0] load_delay_field;
  reg no_dma_flag;
  reg [7:0] present_cylinder_value [0:3];
  reg [7:0] target_cylinder_value [0:3];
  reg [3:0] seeking_q;
  reg [3:0] seek_done_q;
  reg [3:0] recal_q;
  reg [23:0] step_tmr_q;
  reg [31:0] delay_q;
  reg [13:0] byte_cnt_q;
  reg [7:0] sect_cnt_q;
  reg xfer_req_q;
  reg scan_ok_q;
  // Result byte loaded into o_host_data; ready waits for it so no stale byte is seen
  reg res_shown_q;

  wire [7:0] op = cmd_q[0];
  wire [4:0] op_lo = op[4:0];
  wire wr_data = i_wr_strobe & i_port_select_line;
  wire rd_data = i_rd_strobe & i_port_select_line;

  // Opcode length lookup, don't-care upper bits masked by using b[4:0]
  function [3:0] cmd_bytes;
    input [7:0] b;
    begin
      if (b == `OP_SENSE_INT) cmd_bytes = 4'h1;
      else if (b == `OP_SPECIFY) cmd_bytes = 4'h3;
      else case (b[4:0])
        `OP_READ_ID: cmd_bytes = 4'h2;
        `OP_FORMAT: cmd_bytes = 4'h6;
        `OP_SCAN_EQ, `OP_SCAN_LE, `OP_SCAN_HE: cmd_bytes = 4'h9;
        `OP_RECAL: cmd_bytes = 4'h2;
        `OP_DRIVE_STAT: cmd_bytes = 4'h2;
        `OP_SEEK: cmd_bytes = 4'h3;
        default: cmd_bytes = 4'h1;
      endcase
    end
  endfunction

  wire [1:0] unit = cmd_q[1][1:0];
  wire is_scan = (op_lo == `OP_SCAN_EQ) | (op_lo == `OP_SCAN_LE) | (op_lo == `OP_SCAN_HE);
  wire [7:0] st0 = {5'h00, cmd_q[1][2:0]};
  wire [13:0] sect_bytes = 14'h0080 << ((cmd_q[5][3:0] > `MAX_SECTOR_SHIFT) ?
                           `MAX_SECTOR_SHIFT : cmd_q[5][3:0]);
  wire [13:0] fmt_bytes = 14'h0080 << ((cmd_q[2][3:0] > `MAX_SECTOR_SHIFT) ?
                          `MAX_SECTOR_SHIFT : cmd_q[2][3:0]);
  wire [31:0] step_cycles = MS_CYCLES * (5'h10 - {1'b0, step_interval_field});
  wire [31:0] load_cycles = MS_CYCLES * {24'h0, load_delay_field, 1'b0};
  wire [31:0] unload_cycles = MS_CYCLES * {24'h0, unload_delay_field, 4'h0};

  assign o_cmd_busy = (state_q != ST_IDLE) && (state_q != ST_CMD || cmd_idx_q != 4'h0);
  assign o_result_ready = (state_q == ST_RES) && res_shown_q;
  assign o_exec_phase = (state_q == ST_EXEC) || (state_q == ST_SETTLE);
  assign o_int_req = (xfer_req_q & no_dma_flag) | (state_q == ST_RES) | (|seek_done_q);
  assign o_dma_req = xfer_req_q & ~no_dma_flag;

  wire xfer_ack = no_dma_flag ? (i_wr_strobe | i_rd_strobe) : i_dma_ack;
  integer k;

  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cmd_idx_q <= 4'h0;
      cmd_len_q <= 4'h1;
      res_idx_q <= 3'h0;
      res_len_q <= 3'h0;
      step_interval_field <= 4'h0;
      unload_delay_field <= 4'h0;
      load_delay_field <= 7'h00;
      no_dma_flag <= 1'b0;
      seeking_q <= 4'h0;
      seek_done_q <= 4'h0;
      recal_q <= 4'h0;
      step_tmr_q <= 24'h000000;
      delay_q <= 32'h00000000;
      byte_cnt_q <= 14'h0000;
      sect_cnt_q <= 8'h00;
      xfer_req_q <= 1'b0;
      scan_ok_q <= 1'b0;
      res_shown_q <= 1'b0;
      o_host_data <= 8'h00;
      o_step <= 1'b0;
      o_step_dir <= 1'b0;
      o_unit_select <= 2'h0;
      o_head_select_bit <= 1'b0;
      o_head_load <= 1'b0;
      o_write_byte_valid <= 1'b0;
      o_write_byte <= 8'h00;
      o_scan_match <= 1'b0;
      for (k = 0; k < 9; k = k + 1) cmd_q[k] <= 8'h00;
      for (k = 0; k < 7; k = k + 1) res_q[k] <= 8'h00;
      for (k = 0; k < 4; k = k + 1) begin
        present_cylinder_value[k] <= 8'h00;
        target_cylinder_value[k] <= 8'h00;
      end
    end else begin
      o_step <= 1'b0;
      o_write_byte_valid <= 1'b0;
      // Background stepping shared by all drives, one pulse per interval
      if (step_tmr_q != 24'h000000) begin
        step_tmr_q <= step_tmr_q - 24'h000001;
      end else if (|seeking_q) begin
        step_tmr_q <= step_cycles[23:0];
        for (k = 0; k < 4; k = k + 1) begin
          if (seeking_q[k]) begin
            if (recal_q[k] ? (i_track_zero && o_unit_select == k[1:0]) :
                (present_cylinder_value[k] == target_cylinder_value[k])) begin
              seeking_q[k] <= 1'b0;
              seek_done_q[k] <= 1'b1;
              if (recal_q[k]) present_cylinder_value[k] <= 8'h00;
            end else begin
              o_step <= 1'b1;
              o_step_dir <= recal_q[k] ? 1'b0 : (target_cylinder_value[k] > present_cylinder_value[k]);
              if (recal_q[k] || target_cylinder_value[k] < present_cylinder_value[k])
                present_cylinder_value[k] <= present_cylinder_value[k] - 8'h01;
              else
                present_cylinder_value[k] <= present_cylinder_value[k] + 8'h01;
            end
          end
        end
      end
      case (state_q)
        ST_IDLE, ST_CMD: begin
          if (state_q == ST_IDLE && o_head_load) begin
            if (delay_q == 32'h00000000) o_head_load <= 1'b0;
            else delay_q <= delay_q - 32'h00000001;
          end
          if (wr_data) begin
            cmd_q[cmd_idx_q] <= i_host_data;
            state_q <= ST_CMD;
            if (cmd_idx_q == 4'h0) cmd_len_q <= cmd_bytes(i_host_data);
            if ((cmd_idx_q == 4'h0 ? cmd_bytes(i_host_data) : cmd_len_q) == cmd_idx_q + 4'h1) begin
              cmd_idx_q <= 4'h0;
              state_q <= ST_EXEC;
              byte_cnt_q <= 14'h0000;
              sect_cnt_q <= 8'h00;
              scan_ok_q <= 1'b1;
            end else begin
              cmd_idx_q <= cmd_idx_q + 4'h1;
            end
          end
        end
        ST_EXEC: begin
          res_idx_q <= 3'h0;
          o_unit_select <= unit;
          o_head_select_bit <= cmd_q[1][2];
          if (op == `OP_SENSE_INT) begin
            res_len_q <= 3'h2;
            state_q <= ST_RES;
            res_q[0] <= `INVALID_STATUS;
            for (k = 3; k >= 0; k = k - 1) begin
              if (seek_done_q[k]) begin
                res_q[0] <= `SEEK_END_BIT | k[7:0];
                res_q[1] <= present_cylinder_value[k];
              end
            end
            if (|seek_done_q) begin
              for (k = 3; k >= 0; k = k - 1)
                if (seek_done_q[k] && !(|(seek_done_q & ((4'h1 << k) - 4'h1)))) seek_done_q[k] <= 1'b0;
            end else res_len_q <= 3'h1;
          end else if (op == `OP_SPECIFY) begin
            step_interval_field <= cmd_q[1][7:4];
            unload_delay_field <= cmd_q[1][3:0];
            load_delay_field <= cmd_q[2][7:1];
            no_dma_flag <= cmd_q[2][0];
            state_q <= ST_IDLE;
          end else if (op_lo == `OP_SEEK || op_lo == `OP_RECAL) begin
            target_cylinder_value[unit] <= (op_lo == `OP_SEEK) ? cmd_q[2] : 8'h00;
            recal_q[unit] <= (op_lo == `OP_RECAL);
            seeking_q[unit] <= 1'b1;
            seek_done_q[unit] <= 1'b0;
            state_q <= ST_IDLE;
          end else if (op_lo == `OP_DRIVE_STAT) begin
            res_q[0] <= {1'b0, 1'b0, i_drive_ready[unit], 1'b0, i_track_zero, cmd_q[1][2:0]};
            res_len_q <= 3'h1;
            state_q <= ST_RES;
          end else if (op_lo == `OP_VERSION) begin
            res_q[0] <= `VERSION_STATUS;
            res_len_q <= 3'h1;
            state_q <= ST_RES;
          end else if (op_lo == `OP_READ_ID || op_lo == `OP_FORMAT || is_scan) begin
            if (!o_head_load) begin
              o_head_load <= 1'b1;
              delay_q <= load_cycles;
              state_q <= ST_SETTLE;
            end else state_q <= ST_SETTLE;
          end else begin
            res_q[0] <= `INVALID_STATUS;
            res_len_q <= 3'h1;
            state_q <= ST_RES;
          end
        end
        ST_SETTLE: begin
          if (delay_q != 32'h00000000) begin
            delay_q <= delay_q - 32'h00000001;
          end else if (op_lo == `OP_READ_ID) begin
            if (i_id_valid) begin
              o_host_data <= i_id_fields[31:24];
              res_q[0] <= st0;
              res_q[1] <= 8'h00;
              res_q[2] <= 8'h00;
              res_q[3] <= i_id_fields[31:24];
              res_q[4] <= i_id_fields[23:16];
              res_q[5] <= i_id_fields[15:8];
              res_q[6] <= i_id_fields[7:0];
              res_len_q <= 3'h7;
              state_q <= ST_RES;
            end
          end else begin
            // Format and scan: one byte per handshake
            if (!xfer_req_q) xfer_req_q <= 1'b1;
            else if (xfer_ack) begin
              xfer_req_q <= 1'b0;
              byte_cnt_q <= byte_cnt_q + 14'h0001;
              if (is_scan) begin
                if (i_disk_byte_valid) begin
                  if (op_lo == `OP_SCAN_EQ && i_disk_byte != i_host_data) scan_ok_q <= 1'b0;
                  if (op_lo == `OP_SCAN_HE && i_disk_byte < i_host_data) scan_ok_q <= 1'b0;
                  if (op_lo == `OP_SCAN_LE && i_disk_byte > i_host_data) scan_ok_q <= 1'b0;
                end
              end else begin
                o_write_byte_valid <= 1'b1;
                o_write_byte <= i_host_data;
              end
              if (i_terminal_count ||
                  (is_scan ? byte_cnt_q + 14'h0001 == sect_bytes :
                   (sect_cnt_q + 8'h01 == cmd_q[3] && i_index))) begin
                o_scan_match <= scan_ok_q;
                res_q[0] <= st0;
                res_q[1] <= 8'h00;
                res_q[2] <= is_scan ? {4'h0, scan_ok_q, 3'h0} : 8'h00;
                res_q[3] <= cmd_q[2];
                res_q[4] <= cmd_q[3];
                res_q[5] <= is_scan ? cmd_q[4] : cmd_q[3];
                res_q[6] <= is_scan ? cmd_q[5] : cmd_q[2];
                res_len_q <= 3'h7;
                state_q <= ST_RES;
              end else if (!is_scan && byte_cnt_q + 14'h0001 == fmt_bytes) begin
                byte_cnt_q <= 14'h0000;
                sect_cnt_q <= sect_cnt_q + 8'h01;
              end
            end
          end
        end
        ST_RES: begin
          xfer_req_q <= 1'b0;
          o_host_data <= res_q[res_idx_q];
          res_shown_q <= 1'b1;
          if (rd_data && res_shown_q) begin
            if (res_idx_q + 3'h1 == res_len_q) begin
              state_q <= ST_IDLE;
              res_shown_q <= 1'b0;
              delay_q <= unload_cycles;
            end else begin
              res_idx_q <= res_idx_q + 3'h1;
              o_host_data <= res_q[res_idx_q + 3'h1];
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // fdc_command_decoder

// ===== rtl/fdc_consts.vh
`ifndef FDC_CONSTS_VH
`define FDC_CONSTS_VH
`define OP_READ_ID 5'h0A
`define OP_FORMAT 5'h0D
`define OP_SCAN_EQ 5'h11
`define OP_SCAN_LE 5'h19
`define OP_SCAN_HE 5'h1D
`define OP_RECAL 5'h07
`define OP_SENSE_INT 8'h08
`define OP_SPECIFY 8'h03
`define OP_DRIVE_STAT 5'h04
`define OP_VERSION 5'h10
`define OP_SEEK 5'h0F
`define INVALID_STATUS 8'h80
`define VERSION_STATUS 8'hA5
`define CLK_MHZ 125
`define MS_CYCLES (`CLK_MHZ * 1000)
`define MAX_SECTOR_SHIFT 4'h6
`define SEEK_END_BIT 8'h20
`endif

// ===== tb/fdc_checker_sva.sv
`timescale 1ns/1ps
module fdc_checker (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_wr_strobe,
  input wire i_rd_strobe,
  input wire i_port_select_line,
  input wire [7:0] i_host_data,
  input wire [7:0] o_host_data,
  input wire o_cmd_busy,
  input wire o_result_ready,
  input wire o_exec_phase,
  input wire o_int_req,
  input wire o_dma_req,
  input wire o_step
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // Opcode taken only when no command is open, so parameter bytes never match
  sequence taken(logic [7:0] op);
    i_wr_strobe && i_port_select_line && !o_cmd_busy && i_host_data == op;
  endsequence
  sequence shows(logic [7:0] v);
    ##3 o_result_ready && o_host_data == v;
  endsequence
  version_byte_a: assert property (taken(8'h10) |-> shows(8'hA5)) else $error("version byte wrong");
  dont_care_a: assert property (taken(8'hF0) |-> shows(8'hA5)) else $error("masked opcode wrong");
  invalid_op_a: assert property (taken(8'h1F) |-> shows(8'h80)) else $error("invalid opcode status wrong");
  sense_result_a: assert property (taken(8'h08) |-> ##3 o_result_ready) else $error("sense result missing");
  timing_silent_a: assert property (taken(8'h03) |=> !o_result_ready [*6]) else $error("timing setup result");
  recal_silent_a: assert property (taken(8'h07) |=> !o_result_ready [*6]) else $error("recalibrate result");
  result_holds_a: assert property (o_result_ready && !i_rd_strobe |=> o_result_ready && $stable(o_host_data))
    else $error("result byte moved");
  result_int_a: assert property (o_result_ready |-> o_int_req) else $error("result without interrupt");
  dma_exec_a: assert property (o_dma_req |-> o_exec_phase) else $error("dma request outside execution");
  step_pulse_a: assert property (o_step |=> !o_step) else $error("step pulse too long");
  status_port_a: assert property (i_wr_strobe && !i_port_select_line && !o_cmd_busy |=> !o_cmd_busy)
    else $error("status port write taken");
endmodule // fdc_checker
bind fdc_command_decoder fdc_checker chk_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe), .i_port_select_line(i_port_select_line),
  .i_host_data(i_host_data), .o_host_data(o_host_data), .o_cmd_busy(o_cmd_busy),
  .o_result_ready(o_result_ready), .o_exec_phase(o_exec_phase), .o_int_req(o_int_req),
  .o_dma_req(o_dma_req), .o_step(o_step));

// ===== tb/fdc_drive_model.sv
`timescale 1ns/1ps
module fdc_drive_model #(
  parameter [31:0] ID_FIELDS = 32'h0300_0702
) (
  input wire i_core_clk,
  input wire i_step,
  input wire i_step_dir,
  input wire [1:0] i_unit_select,
  input wire i_exec_phase,
  input wire i_dma_req,
  output wire o_track_zero,
  output reg o_index,
  output wire o_id_valid,
  output wire [31:0] o_id_fields,
  output reg o_dma_ack
);
  // Heads start off track zero, so recalibrate really has to step
  integer cyl [0:3];
  integer dly;
  initial begin
    cyl[0] = 2;
    cyl[1] = 2;
    cyl[2] = 2;
    cyl[3] = 2;
    dly = 0;
    o_index = 1'b0;
    o_dma_ack = 1'b0;
  end
  assign o_track_zero = (cyl[i_unit_select] == 0);
  assign o_id_valid = i_exec_phase && dly >= 5;
  assign o_id_fields = o_id_valid ? ID_FIELDS : ~ID_FIELDS;
  always @(posedge i_core_clk) begin
    if (i_step) begin
      cyl[i_unit_select] <= i_step_dir ? cyl[i_unit_select] + 1 : cyl[i_unit_select] - 1;
    end
    dly <= i_exec_phase ? dly + 1 : 0;
    o_index <= ($time % 512) < 16;
    o_dma_ack <= i_dma_req && !o_dma_ack;
  end
endmodule // fdc_drive_model

// ===== tb/tb_fdc_command_decoder.sv
`timescale 1ns/1ps
module tb_fdc_command_decoder;
  reg clk, resetn, wr, rd, ps;
  reg [7:0] din;
  wire [7:0] dout, wbyte;
  wire busy, ready, exec, irq, dreq, ack, step, dir, head, hload, wvalid, match, trk0, idx, idv;
  wire [1:0] unit;
  wire [31:0] idf;
  integer num_errors, comparisons, steps;
  reg last_dir;
  fdc_command_decoder #(.MS_CYCLES(10)) dut_u (.i_core_clk(clk), .i_resetn(resetn), .i_wr_strobe(wr),
    .i_rd_strobe(rd), .i_port_select_line(ps), .i_host_data(din), .i_dma_ack(ack), .i_terminal_count(1'b0),
    .i_index(idx), .i_track_zero(trk0), .i_id_valid(idv), .i_id_fields(idf), .i_disk_byte_valid(1'b0),
    .i_disk_byte(8'h00), .i_drive_ready(4'hF), .o_host_data(dout), .o_cmd_busy(busy), .o_result_ready(ready),
    .o_exec_phase(exec), .o_int_req(irq), .o_dma_req(dreq), .o_step(step), .o_step_dir(dir),
    .o_unit_select(unit), .o_head_select_bit(head), .o_head_load(hload), .o_write_byte_valid(wvalid),
    .o_write_byte(wbyte), .o_scan_match(match));
  fdc_drive_model drv_u (.i_core_clk(clk), .i_step(step), .i_step_dir(dir), .i_unit_select(unit),
    .i_exec_phase(exec), .i_dma_req(dreq), .o_track_zero(trk0), .o_index(idx), .o_id_valid(idv),
    .o_id_fields(idf), .o_dma_ack(ack));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (step) begin
      steps <= steps + 1;
      last_dir <= dir;
    end
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task check(input [8*12:1] what, input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task put(input [7:0] b, input sel);
    begin
      @(negedge clk);
      wr = 1'b1;
      ps = sel;
      din = b;
      @(negedge clk);
      wr = 1'b0;
      din = ~b;
    end
  endtask
  // Waits for the byte, compares the masked bits, then pops it
  task get(input [7:0] exp, input [7:0] mask);
    integer n;
    begin
      n = 0;
      while (ready !== 1'b1 && n < 300) begin
        @(negedge clk);
        n = n + 1;
      end
      check("result ready", {7'h00, ready}, 8'h01);
      check("result byte", dout & mask, exp & mask);
      ps = 1'b1;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
    end
  endtask
  task wait_seek;
    integer n;
    begin
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(negedge clk);
        n = n + 1;
      end
      check("seek end", {7'h00, irq}, 8'h01);
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    num_errors = num_errors + 1;
    finish_test;
  end
  initial begin
    {resetn, wr, rd, ps, din, last_dir} = 0;
    {num_errors, comparisons, steps} = 0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    put(8'h10, 1'b1);
    get(8'hA5, 8'hFF);
    put(8'hF0, 1'b1);
    get(8'hA5, 8'hFF);
    put(8'h1F, 1'b1);
    get(8'h80, 8'hFF);
    put(8'h08, 1'b1);
    get(8'h80, 8'hFF);
    put(8'h10, 1'b0);
    repeat (3) @(negedge clk);
    check("status port", {7'h00, ready}, 8'h00);
    $display("decode test done");
    put(8'h03, 1'b1);
    put(8'hF1, 1'b1);
    put(8'h02, 1'b1);
    repeat (6) @(negedge clk);
    check("timing setup", {7'h00, ready}, 8'h00);
    steps = 0;
    put(8'h07, 1'b1);
    put(8'h01, 1'b1);
    wait_seek;
    check("recal steps", steps[7:0], 8'h02);
    check("recal dir", {7'h00, last_dir}, 8'h00);
    put(8'h08, 1'b1);
    get(8'h21, 8'hFF);
    get(8'h00, 8'hFF);
    put(8'h04, 1'b1);
    put(8'h05, 1'b1);
    get(8'h2D, 8'hFF);
    steps = 0;
    put(8'h0F, 1'b1);
    put(8'h01, 1'b1);
    put(8'h03, 1'b1);
    wait_seek;
    check("seek steps", steps[7:0], 8'h03);
    check("seek dir", {7'h00, last_dir}, 8'h01);
    put(8'h08, 1'b1);
    get(8'h21, 8'hFF);
    get(8'h03, 8'hFF);
    $display("seek test done");
    put(8'h4A, 1'b1);
    put(8'h00, 1'b1);
    get(8'h00, 8'h07);
    get(8'h00, 8'h00);
    get(8'h00, 8'h00);
    get(8'h03, 8'hFF);
    get(8'h00, 8'hFF);
    get(8'h07, 8'hFF);
    get(8'h02, 8'hFF);
    $display("read id test done");
    finish_test;
  end
endmodule // tb_fdc_command_decoder
